// [src/gsp_status_publisher.sv]
// Status publisher: selects operands into bit pairs and paces the sends.
`default_nettype none
`include "gsp_defines.svh"
module gsp_status_publisher #(
  parameter int NUM_OPERANDS = 256,
  parameter int TICKS_PER_SEC = `GSP_TICKS_PER_SEC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Internal logic operands, index 0 is the constant Off
  input wire logic [NUM_OPERANDS-1:0] operandBus,
  // Configuration
  input wire gsp_pkg::gsp_predef_sel_t predefined_pair_source_select,
  input wire gsp_pkg::gsp_user_sel_t user_pair_source_select,
  input wire logic [`GSP_NUM_PREDEF-1:0] predefined_pair_event_enable,
  input wire logic [`GSP_NUM_USER-1:0] user_pair_event_enable,
  input wire logic [`GSP_PERIOD_W-1:0] idle_resend_period,
  // Event flag clear, one bit per pair
  input wire gsp_pkg::gsp_pairs_t eventClear,
  // Outgoing message
  output logic msgSend,
  output gsp_pkg::gsp_area_t msgArea,
  output logic [`GSP_HOLD_W-1:0] msgHoldSec,
  // Status
  output gsp_pkg::gsp_pairs_t eventFlags,
  output logic [`GSP_PERIOD_W-1:0] activePeriod
);
  import gsp_pkg::*;

  initial begin
    if (NUM_OPERANDS < 2 || NUM_OPERANDS > (1 << `GSP_SEL_W)) begin
      $error("NUM_OPERANDS out of selector range");
    end
  end

  // Operand lookup; out-of-range and Off codes give logic zero
  function automatic logic pickOperand(input gsp_sel_t sel,
                                       input logic [NUM_OPERANDS-1:0] ops);
    logic val;
    val = 1'b0;
    if (sel != `GSP_OPERAND_OFF && int'(sel) < NUM_OPERANDS) begin
      val = ops[sel];
    end
    return val;
  endfunction

  // Pair code: one is the on/closed/available/test sense
  function automatic logic [1:0] pairCode(input logic val);
    return val ? `GSP_PAIR_ON : `GSP_PAIR_OFF;
  endfunction

  // Reset release through two flops
  logic rstMeta, rstSyncN;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // Selected operand states, reserved predefined pairs forced low
  gsp_pairs_t selState;
  genvar g;
  generate
    for (g = 0; g < `GSP_NUM_PREDEF; g++) begin : gPre
      if (g + 1 >= `GSP_RESERVED_FIRST) begin : gRes
        assign selState.predef[g] = 1'b0;
      end else begin : gSel
        assign selState.predef[g] =
          pickOperand(predefined_pair_source_select[g], operandBus);
      end
    end
    for (g = 0; g < `GSP_NUM_USER; g++) begin : gUsr
      assign selState.user[g] =
        pickOperand(user_pair_source_select[g], operandBus);
    end
  endgenerate

  // Registered state of message, flags and timing
  gsp_pairs_t state_reg, state_next;
  gsp_pairs_t flags_reg, flags_next;
  gsp_area_t area_reg, area_next;
  logic send_reg, send_next;
  logic powerUp_reg, powerUp_next;
  logic [`GSP_PERIOD_W-1:0] period_reg, period_next;
  logic [`GSP_HOLD_W-1:0] hold_reg, hold_next;
  logic [`GSP_NUM_PREDEF-1:0] predefEn_reg, predefEn_next;
  logic [`GSP_NUM_USER-1:0] userEn_reg, userEn_next;
  logic idleExpire;
  logic sendNow;
  gsp_pairs_t changed;
  gsp_pairs_t evEnable;

  assign changed = state_reg ^ selState;
  assign evEnable = '{user: userEn_reg, predef: predefEn_reg};
  // Power-up, any change, or idle expiry starts a send
  assign sendNow = powerUp_reg | (|changed) | idleExpire;

  // Timer restarts on every send so idle resends space from the last one
  gsp_idle_timer #(
    .TICKS_PER_SEC(TICKS_PER_SEC)
  ) uTimer (
    .ref_clk(ref_clk),
    .rstSyncN(rstSyncN),
    .restart(sendNow),
    .periodSec(period_reg),
    .expire(idleExpire)
  );

  // Next values of message, flags and settings
  always_comb begin
    state_next = selState;
    powerUp_next = 1'b0;
    send_next = sendNow;
    area_next = area_reg;
    hold_next = hold_reg;
    predefEn_next = predefined_pair_event_enable;
    userEn_next = user_pair_event_enable;
    // Illegal period settings are ignored, last good one stays
    period_next = period_reg;
    if (idle_resend_period >= `GSP_PERIOD_MIN &&
        idle_resend_period <= `GSP_PERIOD_MAX) begin
      period_next = idle_resend_period;
    end
    if (sendNow) begin
      // Undriven user slots above the first 32 send logic zero
      for (int i = 0; i < `GSP_NUM_PAIRS; i++) begin
        area_next[i] = `GSP_PAIR_OFF;
      end
      for (int i = 0; i < `GSP_NUM_PREDEF; i++) begin
        area_next[i] = pairCode(selState.predef[i]);
      end
      for (int i = 0; i < `GSP_NUM_USER; i++) begin
        area_next[`GSP_NUM_PREDEF + i] = pairCode(selState.user[i]);
      end
      hold_next = `GSP_HOLD_W'(period_reg) * `GSP_HOLD_MULT;
    end
    // A change in the clear cycle still sets its flag
    flags_next = (flags_reg & ~eventClear) | (changed & evEnable);
  end

  // Power-up flag is preset so the first cycle after release sends
  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_reg <= '0;
      flags_reg <= '0;
      area_reg <= '0;
      send_reg <= 1'b0;
      powerUp_reg <= 1'b1;
      period_reg <= `GSP_PERIOD_DEF;
      hold_reg <= '0;
      predefEn_reg <= '0;
      userEn_reg <= '0;
    end else begin
      state_reg <= state_next;
      flags_reg <= flags_next;
      area_reg <= area_next;
      send_reg <= send_next;
      powerUp_reg <= powerUp_next;
      period_reg <= period_next;
      hold_reg <= hold_next;
      predefEn_reg <= predefEn_next;
      userEn_reg <= userEn_next;
    end
  end

  assign msgSend = send_reg;
  assign msgArea = area_reg;
  assign msgHoldSec = hold_reg;
  assign eventFlags = flags_reg;
  assign activePeriod = period_reg;
endmodule
`default_nettype wire

// [src/gsp_defines.svh]
// Constants of the status publisher: counts, codes, reset values, timing.
`ifndef GSP_DEFINES_SVH
`define GSP_DEFINES_SVH
`define GSP_NUM_PREDEF 32
`define GSP_NUM_USER 32
`define GSP_NUM_PAIRS 128
`define GSP_SEL_W 8
`define GSP_OPERAND_OFF 8'h00
`define GSP_RESERVED_FIRST 28
`define GSP_PAIR_ON 2'h2
`define GSP_PAIR_OFF 2'h1
`define GSP_PERIOD_W 6
`define GSP_PERIOD_MIN 6'h01
`define GSP_PERIOD_MAX 6'h3c
`define GSP_PERIOD_DEF 6'h3c
`define GSP_HOLD_W 8
`define GSP_HOLD_MULT 8'h03
`define GSP_SECOND_NS 1000000000
`define GSP_CLK_PERIOD_NS 10
`define GSP_TICKS_PER_SEC (`GSP_SECOND_NS / `GSP_CLK_PERIOD_NS)
`endif

// [src/gsp_pkg.sv]
// Types shared by the status publisher, its checker, the receiver model and the testbench.
`default_nettype none
`include "gsp_defines.svh"
package gsp_pkg;
  typedef logic [`GSP_SEL_W-1:0] gsp_sel_t;
  typedef logic [`GSP_NUM_PREDEF-1:0][`GSP_SEL_W-1:0] gsp_predef_sel_t;
  typedef logic [`GSP_NUM_USER-1:0][`GSP_SEL_W-1:0] gsp_user_sel_t;
  // Logic state of every driven pair, predefined in the low half
  typedef struct packed {
    logic [`GSP_NUM_USER-1:0] user;
    logic [`GSP_NUM_PREDEF-1:0] predef;
  } gsp_pairs_t;
  // Two-bit code per pair for the full status area
  typedef logic [`GSP_NUM_PAIRS-1:0][1:0] gsp_area_t;
endpackage
`default_nettype wire

// [src/gsp_idle_timer.sv]
// Idle resend timer: whole seconds from a cycle prescaler.
`default_nettype none
`include "gsp_defines.svh"
module gsp_idle_timer #(
  parameter int TICKS_PER_SEC = `GSP_TICKS_PER_SEC
) (
  // Clock and synchronised reset
  input wire logic ref_clk,
  input wire logic rstSyncN,
  // Control
  input wire logic restart,
  input wire logic [`GSP_PERIOD_W-1:0] periodSec,
  // Result
  output logic expire
);
  localparam int TICK_W = $clog2(TICKS_PER_SEC);

  initial begin
    if (TICKS_PER_SEC < 2) begin
      $error("TICKS_PER_SEC must be at least 2");
    end
  end

  logic [TICK_W-1:0] tick_reg, tick_next;
  logic [`GSP_PERIOD_W-1:0] sec_reg, sec_next;
  logic expire_reg, expire_next;

  // Count cycles to a second, seconds to the period; restart wins
  always_comb begin
    tick_next = tick_reg;
    sec_next = sec_reg;
    expire_next = 1'b0;
    if (restart) begin
      tick_next = '0;
      sec_next = '0;
    end else if (tick_reg == TICK_W'(TICKS_PER_SEC - 1)) begin
      tick_next = '0;
      if (sec_reg + `GSP_PERIOD_W'(1) >= periodSec) begin
        sec_next = '0;
        expire_next = 1'b1;
      end else begin
        sec_next = sec_reg + `GSP_PERIOD_W'(1);
      end
    end else begin
      tick_next = tick_reg + TICK_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      tick_reg <= '0;
      sec_reg <= '0;
      expire_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      sec_reg <= sec_next;
      expire_reg <= expire_next;
    end
  end

  assign expire = expire_reg;
endmodule
`default_nettype wire

// [sim/gsp_status_publisher_monitor.sv]
// Checker bound to the status publisher ports.
`default_nettype none
`include "gsp_defines.svh"
module gsp_status_monitor #(
  parameter int NUM_OPERANDS = 256,
  parameter int TICKS_PER_SEC = 10
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Inputs watched
  input wire logic [NUM_OPERANDS-1:0] operandBus,
  input wire gsp_pkg::gsp_predef_sel_t predefined_pair_source_select,
  input wire gsp_pkg::gsp_user_sel_t user_pair_source_select,
  input wire logic [`GSP_NUM_PREDEF-1:0] predefined_pair_event_enable,
  input wire logic [`GSP_PERIOD_W-1:0] idle_resend_period,
  // Outputs watched
  input wire logic msgSend,
  input wire gsp_pkg::gsp_area_t msgArea,
  input wire logic [`GSP_HOLD_W-1:0] msgHoldSec,
  input wire gsp_pkg::gsp_pairs_t eventFlags,
  input wire logic [`GSP_PERIOD_W-1:0] activePeriod
);
  timeunit 1ns;
  timeprecision 1ps;
  import gsp_pkg::*;
  logic [1:0] rdy_reg, rdy_next;
  logic [31:0] idle_reg, idle_next;
  logic [5:0] per_reg, per_next;
  // Mirror the reset sync; a period change restarts the idle bound
  always_comb begin
    rdy_next = {rdy_reg[0], 1'b1};
    per_next = activePeriod;
    idle_next = (msgSend || per_reg != activePeriod) ? 32'h0 : idle_reg + 1;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdy_reg <= 2'h0;
      idle_reg <= 32'h0;
      per_reg <= 6'h3c;
    end else begin
      rdy_reg <= rdy_next;
      idle_reg <= idle_next;
      per_reg <= per_next;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rdy_reg[1]);
  AST_IDLE: assert property (
    idle_reg <= activePeriod * TICKS_PER_SEC + 1)
    else $error("idle resend late");
  AST_PERIOD: assert property (
    idle_resend_period inside {[1:60]} |=>
    activePeriod == $past(idle_resend_period))
    else $error("period not taken");
  AST_HOLD: assert property (
    msgSend && $stable(activePeriod) |-> msgHoldSec == 3 * activePeriod)
    else $error("hold time wrong");
  AST_RESV: assert property (
    msgSend |-> msgArea[127:64] == {64{2'h1}} && msgArea[31:27] == {5{2'h1}})
    else $error("unused pair not zero");
  AST_PAIR3: assert property (
    msgSend && $stable(operandBus) && $stable(predefined_pair_source_select)
    |-> msgArea[2] == ((predefined_pair_source_select[2] != 0 &&
    operandBus[predefined_pair_source_select[2]]) ? 2'h2 : 2'h1))
    else $error("pair 3 wrong");
  AST_USER1: assert property (
    msgSend && $stable(operandBus) && $stable(user_pair_source_select)
    |-> msgArea[32] == ((user_pair_source_select[0] != 0 &&
    operandBus[user_pair_source_select[0]]) ? 2'h2 : 2'h1))
    else $error("user pair 1 wrong");
  AST_CHANGE: assert property (!msgSend |-> $stable(msgArea))
    else $error("area moved without send");
  AST_FLAG: assert property (
    $rose(eventFlags.predef[2]) |-> msgSend &&
    $past(predefined_pair_event_enable[2], 2))
    else $error("flag without enabled send");
endmodule
bind gsp_status_publisher gsp_status_monitor #(
  .NUM_OPERANDS(NUM_OPERANDS), .TICKS_PER_SEC(TICKS_PER_SEC)) u_mon (
  .ref_clk, .rstn, .operandBus, .predefined_pair_source_select,
  .user_pair_source_select, .predefined_pair_event_enable,
  .idle_resend_period, .msgSend, .msgArea, .msgHoldSec, .eventFlags,
  .activePeriod);
`default_nettype wire

// [sim/gsp_remote_rx.sv]
// Remote receiving relay model: keeps the last status area sent to it.
`default_nettype none
module gsp_remote_rx (
  // Clock and link
  input wire logic ref_clk,
  input wire logic msgSend,
  input wire gsp_pkg::gsp_area_t msgArea,
  // Received copy
  output gsp_pkg::gsp_area_t rxArea,
  output logic [15:0] rxCount
);
  timeunit 1ns;
  timeprecision 1ps;
  import gsp_pkg::*;
  initial rxCount = 16'h0;
  // Listener takes the area only on a send pulse, one cycle late
  always @(posedge ref_clk) begin
    if (msgSend === 1'b1) begin
      rxArea <= msgArea;
      rxCount <= rxCount + 16'h1;
    end
  end
endmodule
`default_nettype wire

// [sim/tb_gsp_status_publisher.sv]
// Testbench for the status publisher with a remote receiver model.
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("Error %s exp %0h got %0h", nm, e, a); end end
module tb_gsp_status_publisher;
  timeunit 1ns;
  timeprecision 1ps;
  import gsp_pkg::*;
  logic ref_clk = 0;
  logic rstn = 0;
  logic [255:0] ops = '0;
  gsp_predef_sel_t psel = '0;
  gsp_user_sel_t usel = '0;
  logic [31:0] pen = '0;
  logic [31:0] uen = '0;
  logic [5:0] per = 6'h3c;
  gsp_pairs_t clr = '0;
  logic msgSend;
  gsp_area_t msgArea, rxArea;
  logic [7:0] hold;
  gsp_pairs_t flags;
  logic [5:0] actPer;
  logic [15:0] rxCount;
  int errors = 0;
  int n_tests = 0;
  int n;
  gsp_status_publisher #(.TICKS_PER_SEC(10)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .operandBus(ops),
    .predefined_pair_source_select(psel), .user_pair_source_select(usel),
    .predefined_pair_event_enable(pen), .user_pair_event_enable(uen),
    .idle_resend_period(per), .eventClear(clr), .msgSend(msgSend),
    .msgArea(msgArea), .msgHoldSec(hold), .eventFlags(flags),
    .activePeriod(actPer));
  gsp_remote_rx u_rx (.ref_clk(ref_clk), .msgSend(msgSend),
    .msgArea(msgArea), .rxArea(rxArea), .rxCount(rxCount));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Inputs always move 1 ns after the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for a send; n counts the cycles taken
  task automatic wait_send(input int lim);
    n = 0;
    repeat (lim) begin
      cyc(1);
      n++;
      if (msgSend === 1'b1) break;
    end
    if (msgSend !== 1'b1) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic t_powerup();
    ops[5] = 1'b1;
    psel[2] = 8'h05;
    psel[27] = 8'h05;
    psel[13] = 8'h06;
    usel[1] = 8'h05;
    cyc(12);
    rstn = 1'b1;
    wait_send(10);
    `CHK("first send", 3, n)
    cyc(1);
    `CHK("rx count", 16'h1, rxCount)
    `CHK("pair 3", 2'h2, rxArea[2])
    `CHK("pair 28", 2'h1, rxArea[27])
    `CHK("pair 14", 2'h1, rxArea[13])
    `CHK("user 1", 2'h1, rxArea[32])
    `CHK("user 2", 2'h2, rxArea[33])
    `CHK("hold", 8'hb4, hold)
    `CHK("flag", 1'b0, flags.predef[2])
    $display("powerup done");
  endtask
  task automatic t_change();
    pen[2] = 1'b1;
    uen[1] = 1'b1;
    cyc(2);
    ops[5] = 1'b0;
    ops[6] = 1'b1;
    wait_send(3);
    `CHK("change delay", 1, n)
    `CHK("pair 3 off", 2'h1, msgArea[2])
    `CHK("pair 14 closed", 2'h2, msgArea[13])
    `CHK("flag set", 1'b1, flags.predef[2])
    `CHK("user flag set", 1'b1, flags.user[1])
    clr.predef[2] = 1'b1;
    cyc(1);
    clr = '0;
    `CHK("flag clear", 1'b0, flags.predef[2])
    `CHK("user flag kept", 1'b1, flags.user[1])
    $display("change done");
  endtask
  task automatic t_idle();
    per = 6'h00;
    cyc(2);
    `CHK("bad period", 6'h3c, actPer)
    per = 6'h01;
    cyc(2);
    `CHK("period", 6'h01, actPer)
    ops[5] = 1'b1;
    wait_send(3);
    `CHK("hold 1s", 8'h03, hold)
    wait_send(30);
    `CHK("idle resend", 11, n)
    $display("idle done");
  endtask
  // Mid-run reset: send and flags clear, period returns to 60, power-up send repeats
  task automatic t_reset();
    rstn = 1'b0;
    cyc(2);
    `CHK("send in reset", 1'b0, msgSend)
    `CHK("period in reset", 6'h3c, actPer)
    `CHK("flags in reset", 64'h0, flags)
    rstn = 1'b1;
    wait_send(10);
    `CHK("resend delay", 3, n)
    `CHK("hold after reset", 8'hb4, hold)
    `CHK("pair 3 again", 2'h2, msgArea[2])
    $display("reset done");
  endtask
  initial begin
    t_powerup();
    t_change();
    t_idle();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
